// *** verilog/scx_serial_top.v ***
`timescale 1ns/1ps
`include "scx_consts.vh"

// Function
// RULE_01: tx clock from pin, rx, or divider
// RULE_02: rx clock from pin, tx, or divider
// RULE_03: 12-bit ratio shared by both directions
// RULE_04: ratio zero stops the divider
// RULE_05: each divided level lasts ratio cycles
// RULE_06: tx inversion never reaches tx pin
// RULE_07: rx inversion never reaches rx pin
// RULE_08: tx pin driven continuously or during transfer
// RULE_09: rx pin driven continuously or during transfer
// RULE_10: software avoids pin input plus continuous output
// RULE_11: external rx clock limit mck/2 or mck/3
// RULE_12: external tx clock limit mck/6 or mck/2
// RULE_13: each tx frame begins on start event
// RULE_14: holding word moves into bit-clocked shifter
// RULE_15: tx empty when holding and shifter empty
// RULE_16: tx ready set when holding word moves
// RULE_17: each direction may follow other's clock/start
// RULE_18: start automatic or on frame sync events
// RULE_19: interrupt when any status pending and unmasked
// RULE_20: continuous start on write or rx enable
// RULE_21: pin clocks and syncs pass two flops
module scx_serial_top #(
    parameter ADDR_W = 8,
    parameter RATIO_W = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // transmit pins
    input wire tx_bit_clock_pin_in,
    output reg tx_bit_clock_pin_out,
    output reg tx_bit_clock_pin_oe,
    input wire tx_frame_sync_pin,
    output reg tx_data_pin,
    // receive pins
    input wire rx_bit_clock_pin_in,
    output reg rx_bit_clock_pin_out,
    output reg rx_bit_clock_pin_oe,
    input wire rx_frame_sync_pin,
    // interrupt
    output reg irq
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
        merge_bytes = old_word;
        for (i = 0; i < 4; i = i + 1)
            if (strb[i])
                merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
    end
endfunction

function start_hit;
    input [2:0] mode;
    input fs_now;
    input fs_prev;
    input other_start;
    begin
        case (mode)
            `SCX_START_CONTINUOUS: start_hit = 1'b1;
            `SCX_START_OTHER: start_hit = other_start;
            `SCX_START_FS_FALL: start_hit = fs_prev & ~fs_now;
            `SCX_START_FS_RISE: start_hit = ~fs_prev & fs_now;
            `SCX_START_FS_LOW: start_hit = ~fs_now;
            `SCX_START_FS_HIGH: start_hit = fs_now;
            `SCX_START_FS_ANY_EDGE: start_hit = fs_prev ^ fs_now;
            default: start_hit = 1'b0;
        endcase
    end
endfunction

// place the word so that the first bit out sits at the shifter end
function [31:0] align_word;
    input [31:0] word;
    input [4:0] datlen;
    input msbf;
    begin
        align_word = msbf ? (word << (5'd31 - datlen)) : word;
    end
endfunction

function [31:0] shift_word;
    input [31:0] word;
    input msbf;
    begin
        shift_word = msbf ? {word[30:0], 1'b0} : {1'b0, word[31:1]};
    end
endfunction

function clock_pick;
    input [1:0] clock_source_select;
    input div_clk;
    input other_clk;
    input pin_clk;
    begin
        case (clock_source_select)
            `SCX_CKS_DIVIDED: clock_pick = div_clk;
            `SCX_CKS_OTHER: clock_pick = other_clk;
            `SCX_CKS_OWN_PIN: clock_pick = pin_clk;
            default: clock_pick = div_clk;
        endcase
    end
endfunction

function pin_drive;
    input [1:0] clock_output_mode;
    input busy;
    begin
        pin_drive = (clock_output_mode == `SCX_CKO_CONTINUOUS) | ((clock_output_mode == `SCX_CKO_TRANSFER) & busy);
    end
endfunction

// ----------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_SHIFT = 3'b100;

reg [31:0] ctrl;
reg [RATIO_W-1:0] ratio;
reg [31:0] tx_clock_mode_register;
reg [31:0] rx_clock_mode_register;
reg [31:0] tx_frame_mode_register;
reg [31:0] tx_holding_register;
reg [31:0] irq_mask;
reg tx_holding_full;
reg [2:0] tx_state;
reg [31:0] tx_shifter;
reg [5:0] bits_left;
reg tx_clk_prev;
reg tf_prev;
reg rf_prev;
reg rx_active;
reg tx_start_pulse;
reg [3:0] pin_sync1;
reg [3:0] pin_sync2;
reg aw_have;
reg w_have;
reg [ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

wire div_clk;
wire tx_en = ctrl[`SCX_CTRL_TX_EN];
wire rx_en = ctrl[`SCX_CTRL_RX_EN];
wire [1:0] tx_cks = tx_clock_mode_register[`SCX_CKS_MSB:`SCX_CKS_LSB];
wire [1:0] rx_cks = rx_clock_mode_register[`SCX_CKS_MSB:`SCX_CKS_LSB];
wire [1:0] tx_cko = tx_clock_mode_register[`SCX_CKO_MSB:`SCX_CKO_LSB];
wire [1:0] rx_cko = rx_clock_mode_register[`SCX_CKO_MSB:`SCX_CKO_LSB];
wire [2:0] tx_start_mode = tx_clock_mode_register[`SCX_START_MSB:`SCX_START_LSB];
wire [2:0] rx_start_mode = rx_clock_mode_register[`SCX_START_MSB:`SCX_START_LSB];
wire [4:0] datlen = tx_frame_mode_register[`SCX_DATLEN_MSB:`SCX_DATLEN_LSB];
wire datdef = tx_frame_mode_register[`SCX_DATDEF_BIT];
wire msbf = tx_frame_mode_register[`SCX_MSBF_BIT];

// synchronised pins: 0 tx clock, 1 rx clock, 2 tx sync, 3 rx sync
wire tk_s = pin_sync2[0];
wire rk_s = pin_sync2[1];
wire tf_s = pin_sync2[2];
wire rf_s = pin_sync2[3];

// ----------------------------------------------------------------
// clock selection
// ----------------------------------------------------------------
// "other" takes the peer's own source, so mutual selection cannot loop
wire tx_own = (tx_cks == `SCX_CKS_OWN_PIN) ? tk_s : div_clk;
wire rx_own = (rx_cks == `SCX_CKS_OWN_PIN) ? rk_s : div_clk;
wire tx_clk_sel = clock_pick(tx_cks, div_clk, rx_own, tk_s); // [RULE_01] [RULE_17]
wire rx_clk_sel = clock_pick(rx_cks, div_clk, tx_own, rk_s); // [RULE_02] [RULE_17]
wire tx_clk = tx_clk_sel ^ tx_clock_mode_register[`SCX_CKI_BIT]; // [RULE_06]
wire tx_fall = tx_clk_prev & ~tx_clk;

wire tx_shift_busy = (tx_state == ST_SHIFT);
wire tx_empty = ~tx_holding_full & ~tx_shift_busy; // [RULE_15]
wire [31:0] status_word = {27'h0, rx_active, 2'h0, tx_empty, ~tx_holding_full}; // [RULE_16]

wire rx_start_event = rx_en & ~rx_active & start_hit(rx_start_mode, rf_s, rf_prev, tx_start_pulse); // [RULE_20]
wire tx_start_event = start_hit(tx_start_mode, tf_s, tf_prev, rx_start_event); // [RULE_18]
wire tx_reload = (tx_start_mode == `SCX_START_CONTINUOUS) & tx_holding_full & tx_en;

wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
wire wr_thr = wr_fire & (aw_addr[ADDR_W-1:2] == `SCX_OFF_TX_HOLDING >> 2);
wire [31:0] ratio_merge = merge_bytes({20'h0, ratio}, w_data, w_strb);

scx_clock_divider #(
    .RATIO_W(RATIO_W)
) u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .ratio(ratio), // [RULE_03] [RULE_04] [RULE_05]
    .div_clk(div_clk)
);

// ----------------------------------------------------------------
// pin synchronisers and edge history
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        pin_sync1 <= 4'h0;
        pin_sync2 <= 4'h0;
        tf_prev <= 1'b0;
        rf_prev <= 1'b0;
        tx_clk_prev <= 1'b0;
    end
    else
    begin
        pin_sync1 <= {rx_frame_sync_pin, tx_frame_sync_pin, rx_bit_clock_pin_in, tx_bit_clock_pin_in}; // [RULE_21]
        pin_sync2 <= pin_sync1;
        tf_prev <= tf_s;
        rf_prev <= rf_s;
        tx_clk_prev <= tx_clk;
    end
end

// ----------------------------------------------------------------
// clock pin drive and interrupt
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        tx_bit_clock_pin_out <= 1'b0;
        tx_bit_clock_pin_oe <= 1'b0;
        rx_bit_clock_pin_out <= 1'b0;
        rx_bit_clock_pin_oe <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        tx_bit_clock_pin_out <= tx_clk_sel;
        tx_bit_clock_pin_oe <= pin_drive(tx_cko, tx_shift_busy); // [RULE_08]
        rx_bit_clock_pin_out <= rx_clk_sel; // [RULE_07]
        rx_bit_clock_pin_oe <= pin_drive(rx_cko, rx_active); // [RULE_09]
        irq <= |(status_word & irq_mask); // [RULE_19]
    end
end

// ----------------------------------------------------------------
// receive start tracking
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
        rx_active <= 1'b0;
    else if (!rx_en)
        rx_active <= 1'b0;
    else if (rx_start_event)
        rx_active <= 1'b1; // [RULE_17] [RULE_18]
end

// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        tx_state <= ST_IDLE;
        tx_shifter <= `SCX_RESET_WORD;
        bits_left <= 6'h00;
        tx_holding_full <= 1'b0;
        tx_start_pulse <= 1'b0;
        tx_data_pin <= 1'b0;
    end
    else
    begin
        tx_start_pulse <= 1'b0;
        case (tx_state)
            ST_IDLE:
            begin
                tx_data_pin <= datdef;
                if (tx_en & tx_holding_full)
                    tx_state <= ST_WAIT;
            end
            ST_WAIT:
            begin
                if (!tx_en)
                    tx_state <= ST_IDLE;
                else if (tx_start_event) // [RULE_13]
                begin
                    tx_shifter <= align_word(tx_holding_register, datlen, msbf); // [RULE_14]
                    bits_left <= {1'b0, datlen} + 6'h01;
                    tx_holding_full <= 1'b0; // [RULE_16]
                    tx_start_pulse <= 1'b1;
                    tx_state <= ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (!tx_en)
                begin
                    tx_data_pin <= datdef;
                    tx_state <= ST_IDLE;
                end
                else if (tx_fall && bits_left != 6'h00)
                begin
                    tx_data_pin <= msbf ? tx_shifter[31] : tx_shifter[0]; // [RULE_14]
                    tx_shifter <= shift_word(tx_shifter, msbf);
                    bits_left <= bits_left - 6'h01;
                end
                else if (tx_fall && tx_reload)
                begin
                    // back-to-back word in continuous mode, no idle bit
                    tx_data_pin <= msbf ? tx_holding_register[datlen] : tx_holding_register[0]; // [RULE_20]
                    tx_shifter <= shift_word(align_word(tx_holding_register, datlen, msbf), msbf);
                    bits_left <= {1'b0, datlen};
                    tx_holding_full <= 1'b0; // [RULE_16]
                    tx_start_pulse <= 1'b1;
                end
                else if (tx_fall)
                begin
                    tx_data_pin <= datdef;
                    tx_state <= ST_IDLE; // [RULE_15]
                end
            end
            default:
                tx_state <= ST_IDLE;
        endcase
        // a write in the cycle of a load still leaves the holding word full
        if (wr_thr)
            tx_holding_full <= 1'b1; // [RULE_20]
    end
end

// ----------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SCX_RESP_OKAY;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        aw_addr <= {ADDR_W{1'b0}};
        w_data <= `SCX_RESET_WORD;
        w_strb <= 4'h0;
        ctrl <= `SCX_RESET_WORD;
        ratio <= {RATIO_W{1'b0}};
        tx_clock_mode_register <= `SCX_RESET_WORD;
        rx_clock_mode_register <= `SCX_RESET_WORD;
        tx_frame_mode_register <= `SCX_RESET_FRAME_MODE;
        tx_holding_register <= `SCX_RESET_WORD;
        irq_mask <= `SCX_RESET_WORD;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_addr <= s_axi_awaddr;
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SCX_RESP_OKAY;
            case (aw_addr)
                `SCX_OFF_CTRL: ctrl <= merge_bytes(ctrl, w_data, w_strb) & 32'h0000_0003;
                `SCX_OFF_RATIO: ratio <= ratio_merge[RATIO_W-1:0]; // [RULE_03]
                `SCX_OFF_TX_CLOCK_MODE: tx_clock_mode_register <= merge_bytes(tx_clock_mode_register, w_data, w_strb);
                `SCX_OFF_RX_CLOCK_MODE: rx_clock_mode_register <= merge_bytes(rx_clock_mode_register, w_data, w_strb);
                `SCX_OFF_TX_FRAME_MODE: tx_frame_mode_register <= merge_bytes(tx_frame_mode_register, w_data, w_strb);
                `SCX_OFF_TX_HOLDING: tx_holding_register <= merge_bytes(tx_holding_register, w_data, w_strb);
                `SCX_OFF_STATUS: s_axi_bresp <= `SCX_RESP_OKAY;
                `SCX_OFF_IRQ_MASK: irq_mask <= merge_bytes(irq_mask, w_data, w_strb) & `SCX_SR_MASK;
                default: s_axi_bresp <= `SCX_RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= `SCX_RESET_WORD;
        s_axi_rresp <= `SCX_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SCX_RESP_OKAY;
        case (s_axi_araddr)
            `SCX_OFF_CTRL: s_axi_rdata <= ctrl;
            `SCX_OFF_RATIO: s_axi_rdata <= {20'h0, ratio};
            `SCX_OFF_TX_CLOCK_MODE: s_axi_rdata <= tx_clock_mode_register;
            `SCX_OFF_RX_CLOCK_MODE: s_axi_rdata <= rx_clock_mode_register;
            `SCX_OFF_TX_FRAME_MODE: s_axi_rdata <= tx_frame_mode_register;
            `SCX_OFF_TX_HOLDING: s_axi_rdata <= tx_holding_register;
            `SCX_OFF_STATUS: s_axi_rdata <= status_word; // [RULE_15] [RULE_19]
            `SCX_OFF_IRQ_MASK: s_axi_rdata <= irq_mask;
            default:
            begin
                s_axi_rdata <= `SCX_RESET_WORD;
                s_axi_rresp <= `SCX_RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule // scx_serial_top

// *** shared/scx_consts.vh ***
`ifndef SCX_CONSTS_VH
`define SCX_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCX_OFF_CTRL 8'h00
`define SCX_OFF_RATIO 8'h04
`define SCX_OFF_TX_CLOCK_MODE 8'h08
`define SCX_OFF_RX_CLOCK_MODE 8'h0c
`define SCX_OFF_TX_FRAME_MODE 8'h10
`define SCX_OFF_TX_HOLDING 8'h14
`define SCX_OFF_STATUS 8'h18
`define SCX_OFF_IRQ_MASK 8'h1c

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define SCX_CTRL_TX_EN 0
`define SCX_CTRL_RX_EN 1

// ----------------------------------------------------------------
// clock mode register fields (tx and rx alike, except CKI, which only tx uses)
// ----------------------------------------------------------------
`define SCX_CKS_LSB 0
`define SCX_CKS_MSB 1
`define SCX_CKO_LSB 2
`define SCX_CKO_MSB 3
`define SCX_CKI_BIT 5
`define SCX_START_LSB 8
`define SCX_START_MSB 10

// clock source select codes
`define SCX_CKS_DIVIDED 2'h0
`define SCX_CKS_OTHER 2'h1
`define SCX_CKS_OWN_PIN 2'h2

// clock output mode codes
`define SCX_CKO_INPUT 2'h0
`define SCX_CKO_CONTINUOUS 2'h1
`define SCX_CKO_TRANSFER 2'h2

// start mode codes
`define SCX_START_CONTINUOUS 3'h0
`define SCX_START_OTHER 3'h1
`define SCX_START_FS_FALL 3'h2
`define SCX_START_FS_RISE 3'h3
`define SCX_START_FS_LOW 3'h4
`define SCX_START_FS_HIGH 3'h5
`define SCX_START_FS_ANY_EDGE 3'h6

// ----------------------------------------------------------------
// tx frame mode fields
// ----------------------------------------------------------------
`define SCX_DATLEN_LSB 0
`define SCX_DATLEN_MSB 4
`define SCX_DATDEF_BIT 5
`define SCX_MSBF_BIT 7

// ----------------------------------------------------------------
// status bits and reset values
// ----------------------------------------------------------------
`define SCX_SR_TX_READY 0
`define SCX_SR_TX_EMPTY 1
`define SCX_SR_RX_ACTIVE 4
`define SCX_SR_MASK 32'h0000_0013
`define SCX_RESET_WORD 32'h0000_0000
`define SCX_RESET_FRAME_MODE 32'h0000_0007

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SCX_RESP_OKAY 2'h0
`define SCX_RESP_SLVERR 2'h2

`endif

// *** verilog/scx_clock_divider.v ***
`timescale 1ns/1ps

module scx_clock_divider #(
    parameter RATIO_W = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire [RATIO_W-1:0] ratio,
    // divided clock level
    output reg div_clk
);

reg [RATIO_W-1:0] count;

// each level lasts ratio master-clock cycles; zero keeps it idle
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        count <= {RATIO_W{1'b0}};
        div_clk <= 1'b0;
    end
    else if (ratio == {RATIO_W{1'b0}})
    begin
        count <= {RATIO_W{1'b0}};
        div_clk <= 1'b0;
    end
    else if (count >= ratio - {{(RATIO_W-1){1'b0}}, 1'b1})
    begin
        count <= {RATIO_W{1'b0}};
        div_clk <= ~div_clk;
    end
    else
    begin
        count <= count + {{(RATIO_W-1){1'b0}}, 1'b1};
    end
end

endmodule // scx_clock_divider

// *** dv/scx_serial_monitor.sv ***
`timescale 1ns/1ps

// ----
// register bus handshake checks
// ----
module scx_serial_monitor (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // write channels
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    // read channels
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_bwait;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_b_answer; s_wtake |=> s_bwait; endproperty
    a_b_answer: assert property (p_b_answer) else $error("late write response");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp not held");
    property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_b_done: assert property (p_b_done) else $error("bresp not retired");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_answer: assert property (p_r_answer) else $error("late read data");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata not held");
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read data not retired");
endmodule // scx_serial_monitor

bind scx_serial_top scx_serial_monitor u_mon (.*);

// *** dv/scx_codec_model.sv ***
`timescale 1ns/1ps

// ----
// far-side codec: frame sync, clock, sampling
// ----
module scx_codec_model (
    // clock
    input logic aclk,
    // from the block
    input logic tx_bit_clock_pin_out,
    input logic tx_data_pin,
    // toward the block
    output logic tx_bit_clock_pin_in,
    output logic tx_frame_sync_pin,
    output logic rx_bit_clock_pin_in,
    output logic rx_frame_sync_pin
);
    // external clock stands still between frames
    initial
    begin
        tx_bit_clock_pin_in = 1'b1;
        tx_frame_sync_pin = 1'b0;
        rx_frame_sync_pin = 1'b0;
    end
    always @* rx_bit_clock_pin_in = tx_bit_clock_pin_in;
    task automatic frame(input bit ext, output logic [7:0] w);
        int i;
        begin
            if (!ext) @(posedge tx_bit_clock_pin_out);
            @(posedge aclk);
            tx_frame_sync_pin <= 1'b1;
            // ninth period gives the trailing fall
            for (i = 0; i < 9; i++)
            begin
                if (ext)
                begin
                    repeat (8) @(posedge aclk);
                    tx_bit_clock_pin_in <= 1'b0;
                    repeat (8) @(posedge aclk);
                    tx_bit_clock_pin_in <= 1'b1;
                end
                else
                    @(posedge tx_bit_clock_pin_out);
                if (i < 8) w = {w[6:0], tx_data_pin};
            end
            tx_frame_sync_pin <= 1'b0;
        end
    endtask
endmodule // scx_codec_model

// *** dv/scx_serial_top_test.sv ***
`timescale 1ns/1ps
`include "scx_consts.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end

module scx_serial_top_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_bit_clock_pin_out, tx_bit_clock_pin_oe, rx_bit_clock_pin_out, rx_bit_clock_pin_oe, tx_data_pin;
    wire tx_bit_clock_pin_in, tx_frame_sync_pin, rx_bit_clock_pin_in, rx_frame_sync_pin;
    int miscompares = 0, cmp_count = 0, n;
    int ratios[3] = '{4095, 1, 3};
    always #20 aclk = ~aclk;
    scx_serial_top u_dut (.*);
    scx_codec_model u_codec (.*);
    // ----
    // bus tasks
    // ----
    task wr(input [7:0] a, input [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            fork
                begin
                    do @(posedge aclk); while (!s_axi_awready);
                    s_axi_awvalid <= 1'b0;
                end
                begin
                    do @(posedge aclk); while (!s_axi_wready);
                    s_axi_wvalid <= 1'b0;
                end
            join
            do @(posedge aclk); while (!s_axi_bvalid);
            `CHK("bresp", `SCX_RESP_OKAY, s_axi_bresp)
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            do @(posedge aclk); while (!s_axi_arready);
            s_axi_arvalid <= 1'b0;
            do @(posedge aclk); while (!s_axi_rvalid);
            `CHK("rdata", e, s_axi_rdata)
            `CHK("rresp", er, s_axi_rresp)
        end
    endtask
    // length of one high level of the tx clock pin
    task hi_len(output int c);
        begin
            c = 0;
            while (tx_bit_clock_pin_out !== 1'b0) @(posedge aclk);
            while (tx_bit_clock_pin_out !== 1'b1) @(posedge aclk);
            while (tx_bit_clock_pin_out === 1'b1)
            begin
                c++;
                @(posedge aclk);
            end
        end
    endtask
    task frame(input bit ext, input [7:0] w);
        begin
            wr(`SCX_OFF_TX_HOLDING, {24'h0, w});
            rd(`SCX_OFF_STATUS, 32'h0, 2'h0);
            `CHK("irq busy", 1'b0, irq)
            fork
                u_codec.frame(ext, got);
                begin
                    repeat (120) @(posedge aclk);
                    `CHK("tx clock oe", ~ext, tx_bit_clock_pin_oe)
                end
            join
            `CHK("tx word", w, got)
            repeat (40) @(posedge aclk);
            rd(`SCX_OFF_STATUS, 32'h3, 2'h0);
            `CHK("irq empty", 1'b1, irq)
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // ----
    // tests
    // ----
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`SCX_OFF_TX_FRAME_MODE, `SCX_RESET_FRAME_MODE, 2'h0);
        rd(`SCX_OFF_STATUS, 32'h3, 2'h0);
        wr(`SCX_OFF_STATUS, 32'h0);
        rd(`SCX_OFF_STATUS, 32'h3, 2'h0);
        rd(8'h20, 32'h0, `SCX_RESP_SLVERR);
        $display("test registers done");
        wr(`SCX_OFF_TX_CLOCK_MODE, 32'h4);
        wr(`SCX_OFF_RX_CLOCK_MODE, 32'h4);
        repeat (30)
        begin
            @(posedge aclk);
            `CHK("divider off", 1'b0, tx_bit_clock_pin_out)
        end
        foreach (ratios[k])
        begin
            wr(`SCX_OFF_RATIO, ratios[k]);
            hi_len(n);
            hi_len(n);
            `CHK("level length", ratios[k], n)
        end
        wr(`SCX_OFF_TX_CLOCK_MODE, 32'h24);
        repeat (24)
        begin
            @(posedge aclk);
            `CHK("tx pin vs rx pin", rx_bit_clock_pin_out, tx_bit_clock_pin_out)
        end
        `CHK("continuous oe", 1'b1, tx_bit_clock_pin_oe)
        `CHK("rx continuous oe", 1'b1, rx_bit_clock_pin_oe)
        $display("test divider done");
        wr(`SCX_OFF_RATIO, 32'hc);
        wr(`SCX_OFF_TX_CLOCK_MODE, 32'h308);
        wr(`SCX_OFF_TX_FRAME_MODE, 32'h87);
        wr(`SCX_OFF_IRQ_MASK, 32'h2);
        wr(`SCX_OFF_CTRL, 32'h1);
        `CHK("idle oe", 1'b0, tx_bit_clock_pin_oe)
        frame(1'b0, 8'ha5);
        wr(`SCX_OFF_TX_CLOCK_MODE, 32'h302);
        frame(1'b1, 8'h3c);
        wr(`SCX_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        `CHK("irq masked", 1'b0, irq)
        $display("test frames done");
        wrap_up;
    end
    initial
    begin
        repeat (60000) @(posedge aclk);
        miscompares++;
        wrap_up;
    end
endmodule // scx_serial_top_test
